/* File: core/hsr_fwd.sv */
// one direction of the re-timing path: captures a byte stream and re-sends it
// assumes receive strobes are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module hsr_fwd
  import hsr_pkg::*;
(
  input  wire logic              clk,       // system clock
  input  wire logic              rst_n,     // synchronised reset
  input  wire logic              pass,      // forwarding allowed
  input  wire logic              rx_active, // packet in progress on source
  input  wire logic              rx_valid,  // byte strobe on source
  input  wire logic [DATA_W-1:0] rx_data,   // received byte
  output logic                   tx_active, // packet in progress on sink
  output logic                   tx_valid,  // byte strobe on sink
  output logic      [DATA_W-1:0] tx_data    // re-timed byte
);
  logic              next_active;
  logic              next_valid;
  logic [DATA_W-1:0] next_data;

  always_comb begin
    next_active = pass & rx_active;
    next_valid  = pass & rx_active & rx_valid;
    next_data   = (pass & rx_valid) ? rx_data : tx_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_active <= 1'b0;
      tx_valid  <= 1'b0;
      tx_data   <= DATA_RST;
    end else begin
      tx_active <= next_active;
      tx_valid  <= next_valid;
      tx_data   <= next_data;
    end
  end

  a_byte_relay: assert property (
    @(posedge clk) disable iff (!rst_n)
    pass && rx_active && rx_valid |=> tx_valid && tx_data == $past(rx_data))
    else $error("byte not relayed one cycle later");
endmodule // hsr_fwd
`default_nettype wire

/* File: core/hsr_pkg.sv */
// constants for the high-speed repeater test forwarding block
// assumes a single 10 MHz clock and byte-wide recovered streams per port
// Operation
// - In high-speed state a test packet arriving on one port is re-timed and sent out of the other port, either way.
// - Test J or Test K seen on one port makes the block drive the same J or K out of the other port.
// - J/K forwarding holds until enable or reset goes low, or the supply is cycled.
// - The high-speed status output is high exactly while the block is in high-speed state.
// - The block is a transparent repeater only, with no host, device or hub logic and no identifier store.
package hsr_pkg;
  localparam int unsigned CLK_KHZ         = 10000;
  localparam int unsigned T_SUSPEND_US    = 3000;
  localparam int unsigned SUSPEND_CYC     = (T_SUSPEND_US * CLK_KHZ) / 1000;
  localparam int unsigned IDLE_W          = 16;
  localparam int unsigned DATA_W          = 8;
  localparam logic [7:0]  DATA_RST        = 8'h00;

  typedef enum logic [1:0] {HSR_OFF, HSR_HS} hsr_link_e;
  typedef enum logic [1:0] {HSR_FREE, HSR_TO_OUT, HSR_TO_IN} hsr_owner_e;
endpackage : hsr_pkg

/* File: core/hsr_top.sv */
// repeater compliance-test forwarding: re-timed packets and latched J/K
// assumes line decoding is done outside and all inputs except nrst (synchronised here) are mclk-synchronous
`timescale 1ns/1ps
`default_nettype none
module hsr_top
  import hsr_pkg::*;
#(
  parameter int unsigned SUSPEND_CYCLES = SUSPEND_CYC
) (
  input  wire logic              mclk,           // 10 MHz clock
  input  wire logic              nrst,           // active-low chip reset
  input  wire logic              enable,         // enable pin
  input  wire logic              hs_link,        // high-speed handshake done
  input  wire logic              fsls_seen,      // full/low-speed signalling
  input  wire logic              intp_rx_active, // packet on internal port
  input  wire logic              intp_rx_valid,  // byte strobe internal
  input  wire logic [DATA_W-1:0] intp_rx_data,   // byte internal
  input  wire logic              intp_test_j,    // test J seen internal
  input  wire logic              intp_test_k,    // test K seen internal
  input  wire logic              extp_rx_active, // packet on external port
  input  wire logic              extp_rx_valid,  // byte strobe external
  input  wire logic [DATA_W-1:0] extp_rx_data,   // byte external
  input  wire logic              extp_test_j,    // test J seen external
  input  wire logic              extp_test_k,    // test K seen external
  output logic                   extp_tx_active, // packet out external
  output logic                   extp_tx_valid,  // byte strobe out external
  output logic      [DATA_W-1:0] extp_tx_data,   // byte out external
  output logic                   intp_tx_active, // packet out internal
  output logic                   intp_tx_valid,  // byte strobe out internal
  output logic      [DATA_W-1:0] intp_tx_data,   // byte out internal
  output logic                   extp_drive_j,   // hold HS J on external
  output logic                   extp_drive_k,   // hold HS K on external
  output logic                   intp_drive_j,   // hold HS J on internal
  output logic                   intp_drive_k,   // hold HS K on internal
  output logic                   hs_state_indicator // high-speed state lamp
);
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  hsr_link_e        link;
  hsr_link_e        next_link;
  hsr_owner_e       owner;
  hsr_owner_e       next_owner;
  logic [IDLE_W-1:0] idle;
  logic [IDLE_W-1:0] next_idle;
  logic             jk_on;
  logic             next_jk_on;
  logic             jk_to_out;
  logic             next_jk_to_out;
  logic             jk_is_k;
  logic             next_jk_is_k;
  logic             next_ind;
  logic             next_oj;
  logic             next_ok;
  logic             next_ij;
  logic             next_ik;
  logic             bus_busy;
  logic             in_test;
  logic             out_test;

  always_comb begin
    in_test  = intp_test_j | intp_test_k;
    out_test = extp_test_j | extp_test_k;
    bus_busy = intp_rx_active | extp_rx_active | jk_on;
    // idle counter models suspend entry when the host stops repeating
    next_idle = (bus_busy || link != HSR_HS) ? '0 :
                (idle == SUSPEND_CYCLES[IDLE_W-1:0]) ? idle :
                idle + 1'b1;
    next_link = link;
    case (link)
      HSR_OFF: if (enable && hs_link && !fsls_seen) begin
        next_link = HSR_HS;
      end
      HSR_HS: if (!enable || (!jk_on && (!hs_link || fsls_seen ||
                  idle == SUSPEND_CYCLES[IDLE_W-1:0]))) begin
        next_link = HSR_OFF;
      end
      default: next_link = HSR_OFF;
    endcase
    // the first port to start a packet owns the path until it ends
    next_owner = owner;
    case (owner)
      HSR_FREE: begin
        if (link == HSR_HS && !jk_on && intp_rx_active) begin
          next_owner = HSR_TO_OUT;
        end else if (link == HSR_HS && !jk_on && extp_rx_active) begin
          next_owner = HSR_TO_IN;
        end
      end
      HSR_TO_OUT: if (!intp_rx_active) next_owner = HSR_FREE;
      HSR_TO_IN:  if (!extp_rx_active) next_owner = HSR_FREE;
      default:    next_owner = HSR_FREE;
    endcase
    // release the path on the same edge that leaves high-speed state
    if (next_link != HSR_HS) begin
      next_owner = HSR_FREE;
    end
    // j/k latch: only a low enable clears it, reset clears the flops
    next_jk_on     = jk_on;
    next_jk_to_out = jk_to_out;
    next_jk_is_k   = jk_is_k;
    if (!enable) begin
      next_jk_on = 1'b0;
    end else if (!jk_on && link == HSR_HS && (in_test || out_test)) begin
      next_jk_on     = 1'b1;
      next_jk_to_out = in_test;
      next_jk_is_k   = in_test ? intp_test_k : extp_test_k;
    end
    next_oj  = next_jk_on &  next_jk_to_out & ~next_jk_is_k;
    next_ok  = next_jk_on &  next_jk_to_out &  next_jk_is_k;
    next_ij  = next_jk_on & ~next_jk_to_out & ~next_jk_is_k;
    next_ik  = next_jk_on & ~next_jk_to_out &  next_jk_is_k;
    next_ind = (next_link == HSR_HS);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link               <= HSR_OFF;
      owner              <= HSR_FREE;
      idle               <= '0;
      jk_on              <= 1'b0;
      jk_to_out          <= 1'b0;
      jk_is_k            <= 1'b0;
      extp_drive_j       <= 1'b0;
      extp_drive_k       <= 1'b0;
      intp_drive_j       <= 1'b0;
      intp_drive_k       <= 1'b0;
      hs_state_indicator <= 1'b0;
    end else begin
      link               <= next_link;
      owner              <= next_owner;
      idle               <= next_idle;
      jk_on              <= next_jk_on;
      jk_to_out          <= next_jk_to_out;
      jk_is_k            <= next_jk_is_k;
      extp_drive_j       <= next_oj;
      extp_drive_k       <= next_ok;
      intp_drive_j       <= next_ij;
      intp_drive_k       <= next_ik;
      hs_state_indicator <= next_ind;
    end
  end

  // plain data relay only: no protocol engine and no identifier storage
  hsr_fwd u_to_out (
    .clk       (mclk),
    .rst_n     (rst_n),
    .pass      (next_owner == HSR_TO_OUT),
    .rx_active (intp_rx_active),
    .rx_valid  (intp_rx_valid),
    .rx_data   (intp_rx_data),
    .tx_active (extp_tx_active),
    .tx_valid  (extp_tx_valid),
    .tx_data   (extp_tx_data)
  );

  hsr_fwd u_to_in (
    .clk       (mclk),
    .rst_n     (rst_n),
    .pass      (next_owner == HSR_TO_IN),
    .rx_active (extp_rx_active),
    .rx_valid  (extp_rx_valid),
    .rx_data   (extp_rx_data),
    .tx_active (intp_tx_active),
    .tx_valid  (intp_tx_valid),
    .tx_data   (intp_tx_data)
  );

  sequence s_jk_armed;
    hs_state_indicator && !extp_drive_j && !extp_drive_k &&
    !intp_drive_j && !intp_drive_k && enable;
  endsequence

  a_jk_forward: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_jk_armed ##0 (intp_test_j && !intp_test_k)
    |=> extp_drive_j && !intp_drive_j)
    else $error("test J not forwarded outward");

  // any latched drive, on either port, keeps its value while enabled
  a_jk_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    jk_on && enable |=> jk_on && $stable({extp_drive_j, extp_drive_k,
    intp_drive_j, intp_drive_k}))
    else $error("J/K drive dropped while enabled");

  a_jk_clear: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !enable |=> !extp_drive_j && !extp_drive_k &&
    !intp_drive_j && !intp_drive_k)
    else $error("J/K drive not cleared by low enable");

  a_ind_state: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !hs_state_indicator && enable && hs_link && !fsls_seen
    |=> hs_state_indicator)
    else $error("status lamp did not follow state entry");

  a_no_relay_off: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !hs_state_indicator |-> !extp_tx_valid && !intp_tx_valid ##1 1'b1)
    else $error("relay outside high-speed state");

  a_one_way: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(extp_tx_active && intp_tx_active))
    else $error("both directions active");

  a_fsls_exit: assert property (
    @(posedge mclk) disable iff (!rst_n)
    hs_state_indicator && fsls_seen && !jk_on |=> !hs_state_indicator)
    else $error("full/low-speed did not leave state");
endmodule // hsr_top
`default_nettype wire

/* File: sim/hsr_far.sv */
// far-side port model: sends one four-byte test packet per start pulse
// assumes start and seed come from the bench, synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module hsr_far (
  input  wire logic       mclk,   // bus clock
  input  wire logic       start,  // begin one test packet
  input  wire logic [7:0] seed,   // first byte, later bytes count up
  output logic            active, // packet in progress
  output logic            valid,  // byte strobe
  output logic      [7:0] data    // byte, inverted last byte when idle
);
  logic [2:0] cnt;
  initial cnt = 3'h0;
  // each start reloads the count to 4; the bus idles once it runs down to zero
  always @(posedge mclk) begin
    if (start)
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  assign active = (cnt != 3'h0);
  assign valid  = active;
  assign data   = active ? seed + 8'h04 - {5'h00, cnt} : ~(seed + 8'h03);
endmodule // hsr_far
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the repeater test forwarding block
// assumes a 10 MHz clock; both port partners are hsr_far models
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hsr_pkg::*;
  logic mclk, nrst, enable, hs_link, fsls_seen, ist, est;
  logic ij, ik, ej, ek, ia, iv, ea, ev, eta, etv, ita, itv;
  logic edj, edk, idj, idk, ind;
  logic [7:0] id, ed, etd, itd, isd, esd;
  localparam int unsigned SUSP = 200;
  int bad_count, comparisons;
  hsr_far ifar_i (.mclk(mclk), .start(ist), .seed(isd), .active(ia),
    .valid(iv), .data(id));
  hsr_far efar_i (.mclk(mclk), .start(est), .seed(esd), .active(ea),
    .valid(ev), .data(ed));
  hsr_top #(.SUSPEND_CYCLES(SUSP)) hsr_top_i (.mclk(mclk), .nrst(nrst),
    .enable(enable), .hs_link(hs_link), .fsls_seen(fsls_seen),
    .intp_rx_active(ia), .intp_rx_valid(iv), .intp_rx_data(id),
    .intp_test_j(ij), .intp_test_k(ik), .extp_rx_active(ea),
    .extp_rx_valid(ev), .extp_rx_data(ed), .extp_test_j(ej),
    .extp_test_k(ek), .extp_tx_active(eta), .extp_tx_valid(etv),
    .extp_tx_data(etd), .intp_tx_active(ita), .intp_tx_valid(itv),
    .intp_tx_data(itd), .extp_drive_j(edj), .extp_drive_k(edk),
    .intp_drive_j(idj), .intp_drive_k(idk), .hs_state_indicator(ind));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic reset_check;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    cyc(3);
    chk("indicator reset", 8'(ind), 8'h00);
    chk("relay reset", 8'({eta, etv, ita, itv}), 8'h00);
    $display("reset_check done");
  endtask
  task automatic link_up;
    @(posedge mclk);
    enable <= 1'b1;
    hs_link <= 1'b1;
    fsls_seen <= 1'b0;
    cyc(1);
    chk("indicator", 8'(ind), 8'h01);
    $display("link_up done");
  endtask
  // to_ext: packet from the internal side; n_exp bytes must come out
  task automatic relay(input bit to_ext, input logic [7:0] s, input int n_exp);
    int n;
    n = 0;
    @(posedge mclk);
    if (to_ext) begin
      ist <= 1'b1;
    end else begin
      est <= 1'b1;
    end
    isd <= s;
    esd <= s;
    @(posedge mclk);
    ist <= 1'b0;
    est <= 1'b0;
    repeat (8) begin
      @(negedge mclk);
      if (to_ext ? etv : itv) begin
        chk("relay byte", to_ext ? etd : itd, s + 8'(n));
        chk("relay active", 8'(to_ext ? eta : ita), 8'h01);
        n++;
      end
      chk("back", 8'(to_ext ? {ita, itv} : {eta, etv}), 8'h00);
    end
    chk("relay count", 8'(n), 8'(n_exp));
    chk("relay idle", 8'(to_ext ? eta : ita), 8'h00);
    $display("relay done");
  endtask
  task automatic fsls_drop;
    @(posedge mclk);
    fsls_seen <= 1'b1;
    cyc(2);
    chk("indicator off", 8'(ind), 8'h00);
    relay(1'b1, 8'h33, 0);
    link_up();
    $display("fsls_drop done");
  endtask
  task automatic jk_enable;
    @(posedge mclk);
    ij <= 1'b1;
    cyc(1);
    chk("ext drive j", 8'({edk, edj}), 8'h01);
    @(posedge mclk);
    ek <= 1'b1;
    cyc(3);
    chk("latched ext", 8'({edk, edj}), 8'h01);
    chk("latched int", 8'({idk, idj}), 8'h00);
    @(posedge mclk);
    ij <= 1'b0;
    ek <= 1'b0;
    enable <= 1'b0;
    cyc(2);
    chk("clear by enable", 8'({edk, edj, ind}), 8'h00);
    link_up();
    $display("jk_enable done");
  endtask
  // k beats j on one port, the internal port beats the external one
  task automatic jk_pair;
    @(posedge mclk);
    ij <= 1'b1;
    ik <= 1'b1;
    ej <= 1'b1;
    cyc(1);
    chk("k wins", 8'({edk, edj, idk, idj}), 8'h08);
    cyc(2);
    chk("k held", 8'({edk, edj, idk, idj}), 8'h08);
    @(posedge mclk);
    ij <= 1'b0;
    ik <= 1'b0;
    ej <= 1'b0;
    enable <= 1'b0;
    cyc(1);
    chk("k cleared", 8'({edk, edj, idk, idj}), 8'h00);
    link_up();
    @(posedge mclk);
    ej <= 1'b1;
    cyc(1);
    chk("ext j to int", 8'({edk, edj, idk, idj}), 8'h01);
    @(posedge mclk);
    ej <= 1'b0;
    enable <= 1'b0;
    cyc(1);
    chk("j cleared", 8'({edk, edj, idk, idj}), 8'h00);
    link_up();
    $display("jk_pair done");
  endtask
  // host stops repeating right after state entry: the bus idles out
  task automatic suspend_drop;
    cyc(SUSP - 1);
    chk("no suspend yet", 8'(ind), 8'h01);
    cyc(2);
    chk("suspend exit", 8'(ind), 8'h00);
    link_up();
    $display("suspend_drop done");
  endtask
  task automatic jk_reset;
    @(posedge mclk);
    ek <= 1'b1;
    cyc(1);
    chk("int drive k", 8'({idk, idj}), 8'h02);
    @(posedge mclk);
    ek <= 1'b0;
    nrst <= 1'b0;
    cyc(1);
    chk("clear by reset", 8'({idk, idj, edk, edj}), 8'h00);
    @(posedge mclk);
    nrst <= 1'b1;
    cyc(3);
    link_up();
    relay(1'b1, 8'h5A, 4);
    $display("jk_reset done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #(2000 * 100);
    bad_count++;
    report_and_stop();
  end
  initial begin
    {nrst, enable, hs_link, fsls_seen, ist, est} = 6'h00;
    {ij, ik, ej, ek} = 4'h0;
    isd = 8'h00;
    esd = 8'h00;
    bad_count = 0;
    comparisons = 0;
    reset_check();
    link_up();
    relay(1'b1, 8'hA5, 4);
    relay(1'b0, 8'hC0, 4);
    fsls_drop();
    jk_enable();
    jk_pair();
    suspend_drop();
    jk_reset();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
